// [logic/pma_pkg.sv]
// constants and types shared by the code-bit attachment block
// ---------------------------------------------------------------------------
// How it works
// - far-end fault recognised only after three consecutive fault cycles
// - a fault cycle is 84 ones then one zero, sent and sensed
// - carrier turns on when window holds two non-adjacent zeros
// - carrier turns off after ten consecutive ones
// - each new carrier checked for leading delimiter 1100010001, else error
// - 10-bit history shifts left, new bit enters bit 0, bit 9 oldest
// - fault flag forces link fail; stays false when fault logic is off
// - without negotiation, link control is taken as enable
// - link status is fail, ready or ok
// - stabilisation time lies between 330 and 1000 microseconds
// - fault cycle counter clears on disqualify, saturates at three
// - separate ones counters for generator and detector, never above 84
// - each transmit code-bit yields one nrzi bit, a one toggling the line level
// - each received nrzi bit yields one decoded code-bit to client
// - with fault logic on and no signal detect, the encoder is fed by the fault generator
// - carrier detect and error report may be switched off
// - after onset the detector waits five received bits before checking
// - no signal quality test and no jabber logic here
// - link fails on no signal or disable; ready after stable, then ok
// - generator passes bits with signal on, sends fault cycles without
// - detector accepts an over-long first run of ones
// ---------------------------------------------------------------------------
package pma_pkg;

   // fault indication shape
   localparam logic [1:0] FEF_CYCLES      = 2'h3;
   localparam logic [6:0] FEF_ONES        = 7'h54;

   // carrier detect
   localparam int         WIN_BITS        = 10;
   localparam int         HIST_BITS       = 10;
   localparam logic [9:0] SSD_PATTERN     = 10'h311;
   localparam logic [9:0] ALL_ONES        = 10'h3FF;
   localparam logic [2:0] SSD_WAIT_BITS   = 3'h5;
   localparam int         SSD_LAG         = 0;

   // link stabilisation timer
   localparam int         CLK_MHZ         = 40;
   localparam int         STABILIZE_US    = 330;
   localparam int         STABILIZE_MAX_US = 1000;
   localparam int         STABILIZE_CYC   = STABILIZE_US * CLK_MHZ;
   localparam int         TIMER_W         = 16;

   // link control encoding
   localparam logic [1:0] LC_SCAN         = 2'h0;
   localparam logic [1:0] LC_DISABLE      = 2'h1;
   localparam logic [1:0] LC_ENABLE       = 2'h2;

   // link status encoding
   localparam logic [1:0] LS_FAIL         = 2'h0;
   localparam logic [1:0] LS_READY        = 2'h1;
   localparam logic [1:0] LS_OK           = 2'h2;

   // register map
   localparam logic [3:0] CTRL_ADDR       = 4'h0;
   localparam logic [3:0] STATUS_ADDR     = 4'h4;
   localparam int         CTRL_FEF_BIT    = 0;
   localparam int         CTRL_ANEG_BIT   = 1;
   localparam int         CTRL_CARR_BIT   = 2;
   localparam logic [2:0] CTRL_RESET      = 3'h4;
   localparam int         ST_LINK_LSB     = 0;
   localparam int         ST_CARR_BIT     = 2;
   localparam int         ST_RXERR_BIT    = 3;
   localparam int         ST_FAULT_BIT    = 4;
   localparam int         ST_SIG_BIT      = 5;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {LM_FAIL, LM_STABLE, LM_READY, LM_OK} link_e;
   typedef enum logic [1:0] {CD_OFF, CD_WAIT, CD_ON} carrier_e;

endpackage

// [logic/pma_rx_if.sv]
// decoded receive bit stream shared by the detectors
`timescale 1ns/1ps
interface pma_rx_if;
   logic bit_valid;
   logic code_bit;
   logic fef_en;
   logic carrier_en;
   logic carrier_on;
   logic rx_error;
   logic faulting;

   modport src (output bit_valid, code_bit, fef_en, carrier_en,
                input  carrier_on, rx_error, faulting);
   modport cd  (input  bit_valid, code_bit, carrier_en,
                output carrier_on, rx_error);
   modport fd  (input  bit_valid, code_bit, fef_en,
                output faulting);
endinterface

// [logic/carrier_detect.sv]
// carrier detect with start-of-stream delimiter check
`timescale 1ns/1ps
module carrier_detect
(
   input  wire logic i_sys_clk,
   input  wire logic i_sys_rst,
   pma_rx_if.cd      rx
);

   // any two zeros at least two positions apart
   function automatic logic split_zeros(input logic [9:0] w);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < pma_pkg::WIN_BITS; i++)
      begin
         for (int j = i + 2; j < pma_pkg::WIN_BITS; j++)
         begin
            if (!w[i] && !w[j])
               hit = 1'b1;
         end
      end
      return hit;
   endfunction

   logic [pma_pkg::HIST_BITS-1:0] hist_ff;
   pma_pkg::carrier_e              state_ff;
   logic [2:0]                     wait_ff;
   logic                           err_ff;

   wire [pma_pkg::HIST_BITS-1:0] nxt_hist =
      {hist_ff[pma_pkg::HIST_BITS-2:0], rx.code_bit};
   wire [9:0] win       = nxt_hist[9:0];
   wire [9:0] ssd_win   = nxt_hist[9+pma_pkg::SSD_LAG:pma_pkg::SSD_LAG];
   wire       onset     = split_zeros(win);
   wire       idle_seen = (win == pma_pkg::ALL_ONES);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || !rx.carrier_en)
      begin
         hist_ff  <= '1;
         state_ff <= pma_pkg::CD_OFF;
         wait_ff  <= 3'h0;
         err_ff   <= 1'b0;
      end
      else if (rx.bit_valid)
      begin
         hist_ff <= nxt_hist;
         case (state_ff)
            pma_pkg::CD_OFF:
               if (onset)
               begin
                  state_ff <= pma_pkg::CD_WAIT;
                  wait_ff  <= 3'h1;
                  err_ff   <= 1'b0;
               end
            pma_pkg::CD_WAIT:
               if (wait_ff == pma_pkg::SSD_WAIT_BITS)
               begin
                  err_ff   <= (ssd_win != pma_pkg::SSD_PATTERN);
                  state_ff <= idle_seen ? pma_pkg::CD_OFF
                                        : pma_pkg::CD_ON;
               end
               else
                  wait_ff <= wait_ff + 3'h1;
            pma_pkg::CD_ON:
               if (idle_seen)
                  state_ff <= pma_pkg::CD_OFF;
            default:
               state_ff <= pma_pkg::CD_OFF;
         endcase
      end
   end

   assign rx.carrier_on = (state_ff != pma_pkg::CD_OFF);
   assign rx.rx_error   = err_ff;

endmodule // carrier_detect

// [logic/fef_detect.sv]
// far-end fault indication detector
`timescale 1ns/1ps
module fef_detect
(
   input  wire logic i_sys_clk,
   input  wire logic i_sys_rst,
   pma_rx_if.fd      rx
);

   logic [6:0] ones_ff;
   logic [1:0] cycles_ff;

   wire full_run = (ones_ff == pma_pkg::FEF_ONES);
   // an over-long run is only tolerated before the first counted cycle
   wire too_long = full_run && (cycles_ff != 2'h0);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || !rx.fef_en)
      begin
         ones_ff   <= 7'h00;
         cycles_ff <= 2'h0;
      end
      else if (rx.bit_valid)
      begin
         if (rx.code_bit)
         begin
            if (too_long)
            begin
               ones_ff   <= 7'h00;
               cycles_ff <= 2'h0;
            end
            else if (!full_run)
               ones_ff <= ones_ff + 7'h01;
         end
         else
         begin
            ones_ff <= 7'h00;
            if (!full_run)
               cycles_ff <= 2'h0;
            else if (cycles_ff != pma_pkg::FEF_CYCLES)
               cycles_ff <= cycles_ff + 2'h1;
         end
      end
   end

   assign rx.faulting = (cycles_ff == pma_pkg::FEF_CYCLES);

endmodule // fef_detect

// [logic/pma_top.sv]
// code-bit attachment: nrzi paths, fault generator, link monitor, registers
`timescale 1ns/1ps
module pma_top
#(
   parameter int STABILIZE_CYCLES = pma_pkg::STABILIZE_CYC
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   // client transmit side
   input  wire logic        i_tx_code_valid,
   input  wire logic        i_tx_code_bit,
   // medium transmit side
   output logic             o_tx_nrzi_valid,
   output logic             o_tx_nrzi_bit,
   // medium receive side
   input  wire logic        i_rx_nrzi_valid,
   input  wire logic        i_rx_nrzi_bit,
   input  wire logic        i_signal_detect,
   // client receive side
   output logic             o_rx_code_valid,
   output logic             o_rx_code_bit,
   output logic             o_carrier_on,
   output logic             o_rx_error,
   output logic             o_faulting,
   output logic [1:0]       o_link_status,
   // negotiation control
   input  wire logic [1:0]  i_link_control,
   // axi4-lite slave
   input  wire logic [3:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [3:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready
);

   // ------------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------------
   logic [2:0] ctrl_ff;

   wire fef_en     = ctrl_ff[pma_pkg::CTRL_FEF_BIT];
   wire aneg_en    = ctrl_ff[pma_pkg::CTRL_ANEG_BIT];
   wire carrier_en = ctrl_ff[pma_pkg::CTRL_CARR_BIT];

   // ------------------------------------------------------------------------
   // shared receive stream
   // ------------------------------------------------------------------------
   pma_rx_if rx_bus ();

   carrier_detect u_carrier
   (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .rx        (rx_bus.cd)
   );

   fef_detect u_fef
   (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .rx        (rx_bus.fd)
   );

   // ------------------------------------------------------------------------
   // receive nrzi decode
   // ------------------------------------------------------------------------
   logic rx_line_ff;
   logic rx_valid_ff;
   logic rx_bit_ff;

   // a one is a change of line level since the previous bit
   wire rx_decoded = i_rx_nrzi_bit ^ rx_line_ff;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rx_line_ff  <= 1'b0;
         rx_valid_ff <= 1'b0;
         rx_bit_ff   <= 1'b0;
      end
      else
      begin
         rx_valid_ff <= i_rx_nrzi_valid;
         if (i_rx_nrzi_valid)
         begin
            rx_line_ff <= i_rx_nrzi_bit;
            rx_bit_ff  <= rx_decoded;
         end
      end
   end

   // same bit goes to client and both detectors in the same cycle
   assign rx_bus.bit_valid  = rx_valid_ff;
   assign rx_bus.code_bit   = rx_bit_ff;
   assign rx_bus.fef_en     = fef_en;
   assign rx_bus.carrier_en = carrier_en;

   assign o_rx_code_valid = rx_valid_ff;
   assign o_rx_code_bit   = rx_bit_ff;
   assign o_carrier_on    = rx_bus.carrier_on;
   assign o_rx_error      = rx_bus.rx_error;

   // faulting held false when the fault logic is switched off
   wire faulting = fef_en && rx_bus.faulting;
   assign o_faulting = faulting;

   // ------------------------------------------------------------------------
   // far-end fault generator
   // ------------------------------------------------------------------------
   logic [6:0] gen_ones_ff;

   wire gen_active = fef_en && !i_signal_detect;
   wire gen_done   = (gen_ones_ff == pma_pkg::FEF_ONES);
   wire gen_bit    = !gen_done;
   wire tx_src_bit = gen_active ? gen_bit : i_tx_code_bit;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || !gen_active)
         gen_ones_ff <= 7'h00;
      else if (i_tx_code_valid)
         gen_ones_ff <= gen_done ? 7'h00 : gen_ones_ff + 7'h01;
   end

   // ------------------------------------------------------------------------
   // transmit nrzi encode
   // ------------------------------------------------------------------------
   logic tx_line_ff;
   logic tx_valid_ff;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         tx_line_ff  <= 1'b0;
         tx_valid_ff <= 1'b0;
      end
      else
      begin
         tx_valid_ff <= i_tx_code_valid;
         if (i_tx_code_valid)
            tx_line_ff <= tx_line_ff ^ tx_src_bit;
      end
   end

   assign o_tx_nrzi_valid = tx_valid_ff;
   assign o_tx_nrzi_bit   = tx_line_ff;

   // ------------------------------------------------------------------------
   // link monitor
   // ------------------------------------------------------------------------
   // collision sensing relies on this monitor; no separate self test and
   // no jabber timer are built, the repeater owns jabber protection
   pma_pkg::link_e             link_ff;
   logic [pma_pkg::TIMER_W-1:0] timer_ff;

   wire [1:0] link_ctl = aneg_en ? i_link_control
                                 : pma_pkg::LC_ENABLE;
   wire link_kill  = !i_signal_detect || faulting ||
                     (link_ctl == pma_pkg::LC_DISABLE);
   wire timer_done =
      (timer_ff == pma_pkg::TIMER_W'(STABILIZE_CYCLES - 1));

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || link_kill)
      begin
         link_ff  <= pma_pkg::LM_FAIL;
         timer_ff <= '0;
      end
      else
      begin
         case (link_ff)
            pma_pkg::LM_FAIL:
            begin
               link_ff  <= pma_pkg::LM_STABLE;
               timer_ff <= '0;
            end
            pma_pkg::LM_STABLE:
               if (timer_done)
                  link_ff <= pma_pkg::LM_READY;
               else
                  timer_ff <= timer_ff + pma_pkg::TIMER_W'(1);
            pma_pkg::LM_READY:
               if (link_ctl == pma_pkg::LC_ENABLE)
                  link_ff <= pma_pkg::LM_OK;
            pma_pkg::LM_OK:
               if (link_ctl != pma_pkg::LC_ENABLE)
                  link_ff <= pma_pkg::LM_READY;
            default:
               link_ff <= pma_pkg::LM_FAIL;
         endcase
      end
   end

   // stabilising counts as not intact
   assign o_link_status =
      (link_ff == pma_pkg::LM_OK)    ? pma_pkg::LS_OK    :
      (link_ff == pma_pkg::LM_READY) ? pma_pkg::LS_READY :
                                       pma_pkg::LS_FAIL;

   // ------------------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------------------
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [3:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;

   wire aw_take  = i_awvalid && o_awready;
   wire w_take   = i_wvalid && o_wready;
   wire aw_have  = aw_got_ff || aw_take;
   wire w_have   = w_got_ff || w_take;
   wire do_write = aw_have && w_have && !bvalid_ff;
   wire [3:0]  wr_addr = aw_got_ff ? awaddr_ff : i_awaddr;
   wire [31:0] wr_data = w_got_ff ? wdata_ff : i_wdata;
   wire [3:0]  wr_strb = w_got_ff ? wstrb_ff : i_wstrb;
   wire        wr_ctrl = (wr_addr == pma_pkg::CTRL_ADDR);
   wire        wr_hit  = wr_ctrl || (wr_addr == pma_pkg::STATUS_ADDR);

   assign o_awready = !aw_got_ff && !bvalid_ff;
   assign o_wready  = !w_got_ff && !bvalid_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= pma_pkg::RESP_OKAY;
         ctrl_ff   <= pma_pkg::CTRL_RESET;
      end
      else
      begin
         if (do_write)
         begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? pma_pkg::RESP_OKAY
                                : pma_pkg::RESP_SLVERR;
            if (wr_ctrl && wr_strb[0])
               ctrl_ff <= wr_data[2:0];
         end
         else
         begin
            if (aw_take)
            begin
               aw_got_ff <= 1'b1;
               awaddr_ff <= i_awaddr;
            end
            if (w_take)
            begin
               w_got_ff <= 1'b1;
               wdata_ff <= i_wdata;
               wstrb_ff <= i_wstrb;
            end
            if (bvalid_ff && i_bready)
               bvalid_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------------------
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   wire [31:0] status_word = {26'h0, i_signal_detect, faulting,
                              rx_bus.rx_error, rx_bus.carrier_on,
                              o_link_status};
   wire [31:0] ctrl_word   = {29'h0, ctrl_ff};
   wire rd_ctrl   = (i_araddr == pma_pkg::CTRL_ADDR);
   wire rd_status = (i_araddr == pma_pkg::STATUS_ADDR);
   wire [31:0] rd_word = rd_ctrl   ? ctrl_word   :
                         rd_status ? status_word : 32'h0000_0000;

   assign o_arready = !rvalid_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= pma_pkg::RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= rd_word;
         rresp_ff  <= (rd_ctrl || rd_status) ? pma_pkg::RESP_OKAY
                                             : pma_pkg::RESP_SLVERR;
      end
      else if (rvalid_ff && i_rready)
         rvalid_ff <= 1'b0;
   end

endmodule // pma_top

// [bench/pma_checker.sv]
// concurrent checks on the code-bit attachment top ports
`timescale 1ns/1ps
module pma_checker
#(
   parameter int STABILIZE_CYCLES = 20
)
(
   input wire logic       i_sys_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_tx_code_valid,
   input wire logic       i_tx_code_bit,
   input wire logic       o_tx_nrzi_valid,
   input wire logic       o_tx_nrzi_bit,
   input wire logic       i_rx_nrzi_valid,
   input wire logic       i_signal_detect,
   input wire logic       o_rx_code_valid,
   input wire logic       o_carrier_on,
   input wire logic       o_rx_error,
   input wire logic       o_faulting,
   input wire logic [1:0] o_link_status
);
   // ------------------------------------------------------------------
   // stream and link properties
   // ------------------------------------------------------------------
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   chk_tx_lag: assert property (i_tx_code_valid |=> o_tx_nrzi_valid)
      else $error("transmit line bit missing");
   chk_tx_zero: assert property (
      i_tx_code_valid && !i_tx_code_bit && i_signal_detect
      |=> $stable(o_tx_nrzi_bit)) else $error("line moved on a zero");
   chk_tx_one: assert property (
      i_tx_code_valid && i_tx_code_bit && i_signal_detect
      |=> o_tx_nrzi_bit != $past(o_tx_nrzi_bit))
      else $error("line held on a one");
   chk_tx_idle: assert property (
      !i_tx_code_valid |=> $stable(o_tx_nrzi_bit))
      else $error("line moved without a bit");
   chk_rx_lag: assert property (i_rx_nrzi_valid |=> o_rx_code_valid)
      else $error("decoded bit missing");
   chk_no_signal: assert property (
      !i_signal_detect |=> o_link_status == pma_pkg::LS_FAIL)
      else $error("link not failed without signal");
   chk_fault_fail: assert property (
      o_faulting |=> o_link_status == pma_pkg::LS_FAIL)
      else $error("link not failed while faulting");
   chk_link_code: assert property (o_link_status != 2'h3)
      else $error("link status out of range");
   chk_ok_order: assert property (
      o_link_status == pma_pkg::LS_OK &&
      $past(o_link_status) != pma_pkg::LS_OK
      |-> $past(o_link_status) == pma_pkg::LS_READY)
      else $error("link ok without ready");
   chk_ready_wait: assert property (
      $rose(o_link_status == pma_pkg::LS_READY) &&
      $past(o_link_status) == pma_pkg::LS_FAIL
      |-> $past(i_signal_detect, STABILIZE_CYCLES + 1))
      else $error("link ready before the stable time");
   chk_err_carrier: assert property (
      $rose(o_rx_error) |-> o_carrier_on)
      else $error("receive error outside a carrier");
endmodule // pma_checker

bind pma_top pma_checker #(.STABILIZE_CYCLES(STABILIZE_CYCLES)) u_checker (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
   .i_tx_code_valid(i_tx_code_valid), .i_tx_code_bit(i_tx_code_bit),
   .o_tx_nrzi_valid(o_tx_nrzi_valid), .o_tx_nrzi_bit(o_tx_nrzi_bit),
   .i_rx_nrzi_valid(i_rx_nrzi_valid), .i_signal_detect(i_signal_detect),
   .o_rx_code_valid(o_rx_code_valid), .o_carrier_on(o_carrier_on),
   .o_rx_error(o_rx_error), .o_faulting(o_faulting),
   .o_link_status(o_link_status));

// [bench/pmd_model.sv]
// far-side medium model: loops the transmit line back to the receiver
`timescale 1ns/1ps
module pmd_model
(
   input  wire logic i_clk,
   input  wire logic i_tx_valid,
   input  wire logic i_tx_bit,
   output logic      o_rx_valid,
   output logic      o_rx_bit
);
   logic line_ff = 1'b0;

   // between bits the level toggles, so a stale copy is never trusted
   always_ff @(posedge i_clk)
   begin
      o_rx_valid <= i_tx_valid;
      line_ff    <= i_tx_valid ? i_tx_bit : ~line_ff;
   end
   assign o_rx_bit = line_ff;
endmodule // pmd_model

// [bench/fast_ethernet_pma_carrier_fault_test.sv]
// self-checking bench for the code-bit attachment block
`timescale 1ns/1ps
module fast_ethernet_pma_carrier_fault_test;
   localparam int STAB = 20;
   logic        clk = 1'b0, rst = 1'b1, sig_det = 1'b0;
   logic        tx_valid = 1'b0, tx_bit = 1'b0, fef_on = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [1:0]  link_ctl = pma_pkg::LC_DISABLE;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   wire         tx_nv, tx_nb, rx_nv, rx_nb, rx_cv, rx_cb, carrier, rx_err;
   wire         faulting, awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  link, bresp, rresp;
   wire  [31:0] rdata;
   int          mismatches = 0, checked = 0, gen_cnt = 0;
   logic        exp_q[$];

   initial forever #12.5 clk = ~clk;

   pma_top #(.STABILIZE_CYCLES(STAB)) u_dut (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_tx_code_valid(tx_valid),
      .i_tx_code_bit(tx_bit), .o_tx_nrzi_valid(tx_nv), .o_tx_nrzi_bit(tx_nb),
      .i_rx_nrzi_valid(rx_nv), .i_rx_nrzi_bit(rx_nb),
      .i_signal_detect(sig_det), .o_rx_code_valid(rx_cv),
      .o_rx_code_bit(rx_cb), .o_carrier_on(carrier), .o_rx_error(rx_err),
      .o_faulting(faulting), .o_link_status(link), .i_link_control(link_ctl),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));

   pmd_model u_pmd (.i_clk(clk), .i_tx_valid(tx_nv), .i_tx_bit(tx_nb),
                    .o_rx_valid(rx_nv), .o_rx_bit(rx_nb));

   // ------------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------------
   task check(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // register bus and stream drivers
   // ------------------------------------------------------------------
   task axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] resp, input logic [31:0] exp);
      int   n;
      logic done;
      n = 0;
      done = 0;
      @(posedge clk);
      if (wr)
      begin
         awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
         bready <= 1'b1;
      end
      else
      begin
         araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      end
      while (!done && n < 50)
      begin
         @(posedge clk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (bready && bvalid === 1'b1)
         begin
            bready <= 1'b0; done = 1; check("bresp", bresp, resp);
         end
         if (rready && rvalid === 1'b1)
         begin
            rready <= 1'b0; done = 1; check("rresp", rresp, resp);
            check("rdata", rdata, exp);
         end
      end
      if (!done) begin mismatches++; complete_run(); end
   endtask

   task send(input logic b);
      @(posedge clk);
      tx_valid <= 1'b1;
      tx_bit   <= b;
      if (fef_on && !sig_det)
      begin
         exp_q.push_back(gen_cnt != 84);
         gen_cnt = (gen_cnt == 84) ? 0 : gen_cnt + 1;
      end
      else
         exp_q.push_back(b);
   endtask

   task send_ones(input int n);
      repeat (n) send(1'b1);
   endtask

   task send_bits(input logic [9:0] w);
      for (int i = 9; i >= 0; i--) send(w[i]);
   endtask

   // the receive pipeline is four cycles deep, five leaves margin
   task settle;
      @(posedge clk);
      tx_valid <= 1'b0;
      repeat (5) @(posedge clk);
   endtask

   task wait_link(input logic [1:0] s);
      int n;
      n = 0;
      while (link !== s && n < 100) begin @(posedge clk); n++; end
      check("link status", link, s);
      if (n == 100) complete_run();
   endtask

   always @(posedge clk)
      if (!rst && rx_cv === 1'b1)
         check("rx code bit", rx_cb,
               exp_q.size() ? exp_q.pop_front() : 1'bx);

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      axi(1'b0, pma_pkg::CTRL_ADDR, 32'h0, pma_pkg::RESP_OKAY, 32'h4);
      axi(1'b0, pma_pkg::STATUS_ADDR, 32'h0, pma_pkg::RESP_OKAY, 32'h0);
      axi(1'b0, 4'h8, 32'h0, pma_pkg::RESP_SLVERR, 32'h0);
      axi(1'b1, 4'hC, 32'h1, pma_pkg::RESP_SLVERR, 32'h0);
      axi(1'b1, pma_pkg::CTRL_ADDR, 32'h5, pma_pkg::RESP_OKAY, 32'h0);
      fef_on = 1'b1;
      sig_det <= 1'b1;
      repeat (10) @(posedge clk);
      check("link status", link, pma_pkg::LS_FAIL);
      wait_link(pma_pkg::LS_OK);
      axi(1'b0, pma_pkg::STATUS_ADDR, 32'h0, pma_pkg::RESP_OKAY, 32'h22);
      axi(1'b1, pma_pkg::CTRL_ADDR, 32'h7, pma_pkg::RESP_OKAY, 32'h0);
      link_ctl <= pma_pkg::LC_SCAN;
      wait_link(pma_pkg::LS_READY);
      link_ctl <= pma_pkg::LC_DISABLE;
      wait_link(pma_pkg::LS_FAIL);
      link_ctl <= pma_pkg::LC_ENABLE;
      wait_link(pma_pkg::LS_OK);
      send_ones(12);
      send_bits(10'h35F);
      settle;
      check("carrier", carrier, 1'b1);
      check("rx error", rx_err, 1'b1);
      send_ones(10);
      settle;
      check("carrier", carrier, 1'b0);
      send_bits(10'h311);
      send_ones(7);
      settle;
      check("carrier", carrier, 1'b1);
      check("rx error", rx_err, 1'b0);
      send_ones(3);
      settle;
      check("carrier", carrier, 1'b0);
      gen_cnt = 0;
      sig_det <= 1'b0;
      send_ones(254);
      settle;
      check("faulting", faulting, 1'b0);
      send_ones(1);
      settle;
      check("faulting", faulting, 1'b1);
      axi(1'b0, pma_pkg::STATUS_ADDR, 32'h0, pma_pkg::RESP_OKAY, 32'h10);
      sig_det <= 1'b1;
      send_ones(90);
      settle;
      check("faulting", faulting, 1'b0);
      complete_run();
   end
endmodule // fast_ethernet_pma_carrier_fault_test
